// ===== spisf_defs.svh
// Constants of the SPI status-flag block: offsets, bit positions, reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SPISF_DEFS_SVH
`define SPISF_DEFS_SVH

`define SPISF_ADDR_W      8
`define SPISF_OFF_FLAG    8'h00
`define SPISF_OFF_TXA     8'h04
`define SPISF_OFF_TXB     8'h08
`define SPISF_OFF_PORT    8'h0c
`define SPISF_OFF_PEEK    8'h10
`define SPISF_OFF_VEC1    8'h14
`define SPISF_OFF_GCR1    8'h18
`define SPISF_OFF_ISTAT   8'h1c
`define SPISF_OFF_IMASK   8'h20

`define SPISF_FLAG_W      10
`define SPISF_ERR_W       5
`define SPISF_RXW_W       16
`define SPISF_B_TXE       9
`define SPISF_B_RXF       8
`define SPISF_B_RSV7      7
`define SPISF_B_LOST      6
`define SPISF_B_RSV5      5
`define SPISF_RSVD_LO     10
`define SPISF_RSVD_VAL    22'h004000
`define SPISF_FLAG_IMPL   10'h35f
`define SPISF_ERR_OVWR    5'h13
`define SPISF_GCR_EN      0
`define SPISF_EMPTY_BIT   31

`define SPISF_VEC_NONE    5'h00
`define SPISF_VEC_ERR     5'h11
`define SPISF_VEC_RXF     5'h12
`define SPISF_VEC_LOST    5'h13
`define SPISF_VEC_TXE     5'h14

`define SPISF_RESP_OK     2'h0
`define SPISF_RESP_SLVERR 2'h2

`endif

// ===== spisf_pkg.sv
// Types shared by the SPI status-flag modules.
// Assumes spisf_defs.svh is on the include path.
`include "spisf_defs.svh"

package spisf_pkg;
  typedef logic [`SPISF_ADDR_W-1:0] spisf_addr_t;
  typedef logic [31:0]              spisf_word_t;
  typedef logic [`SPISF_RXW_W-1:0]  spisf_rxw_t;
  typedef logic [`SPISF_FLAG_W-1:0] spisf_flags_t;
  typedef logic [`SPISF_ERR_W-1:0]  spisf_err_t;
  typedef logic [4:0]               spisf_vec_t;
endpackage

// ===== spisf_ifs.sv
// Internal carriers: register access strobes and receive-buffer handshake.
// Assumes spisf_pkg is compiled first.
interface spisf_reg_if;
  import spisf_pkg::*;
  logic        wr_req;
  spisf_addr_t wr_addr;
  spisf_word_t wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_req;
  spisf_addr_t rd_addr;
  spisf_word_t rd_data;
  logic        rd_err;
  modport bus  (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                input  wr_err, rd_data, rd_err);
  modport regs (input  wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

interface spisf_rx_if;
  import spisf_pkg::*;
  logic       rx_done;
  spisf_rxw_t rx_word;
  logic       drain;
  spisf_rxw_t port_data;
  spisf_rxw_t stage_data;
  logic       port_full;
  logic       stage_full;
  logic       loaded;
  logic       lost;
  modport ctl (output rx_done, rx_word, drain,
               input  port_data, stage_data, port_full, stage_full, loaded, lost);
  modport buf_side (input  rx_done, rx_word, drain,
                    output port_data, stage_data, port_full, stage_full, loaded, lost);
endinterface

// ===== spisf_axil.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle strobes.
// Assumes a master that keeps at most one write and one read under way.
`include "spisf_defs.svh"

module spisf_axil
  import spisf_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   awvalid,
  output logic        awready,
  input  spisf_addr_t awaddr,
  input  wire logic   wvalid,
  output logic        wready,
  input  spisf_word_t wdata,
  input  wire logic [3:0] wstrb,
  output logic        bvalid,
  input  wire logic   bready,
  output logic [1:0]  bresp,
  input  wire logic   arvalid,
  output logic        arready,
  input  spisf_addr_t araddr,
  output logic        rvalid,
  input  wire logic   rready,
  output spisf_word_t rdata,
  output logic [1:0]  rresp,
  spisf_reg_if.bus    rif
);
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic next_rvalid;
  logic ar_take;

  assign rif.wr_req  = aw_held && w_held && !bvalid;
  assign ar_take     = arvalid && arready;
  assign rif.rd_req  = ar_take;
  assign rif.rd_addr = araddr;
  assign next_aw_held = (aw_held || (awvalid && awready)) && !rif.wr_req;
  assign next_w_held  = (w_held || (wvalid && wready)) && !rif.wr_req;
  assign next_rvalid  = ar_take || (rvalid && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held;
      wready  <= !next_w_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rif.wr_addr <= '0;
      rif.wr_data <= '0;
      rif.wr_strb <= '0;
    end else begin
      if (awvalid && awready) rif.wr_addr <= awaddr;
      if (wvalid && wready) begin
        rif.wr_data <= wdata;
        rif.wr_strb <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SPISF_RESP_OK;
    end else if (rif.wr_req) begin
      bvalid <= 1'b1;
      bresp  <= rif.wr_err ? `SPISF_RESP_SLVERR : `SPISF_RESP_OK;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= '0;
      rresp   <= `SPISF_RESP_OK;
    end else begin
      rvalid  <= next_rvalid;
      arready <= !next_rvalid;
      if (ar_take) begin
        rdata <= rif.rd_data;
        rresp <= rif.rd_err ? `SPISF_RESP_SLVERR : `SPISF_RESP_OK;
      end
    end
  end
endmodule // spisf_axil

// ===== spisf_rx_holding_stage.sv
// Receive port and internal holding stage, two words deep.
// Assumes rx_done is a one-cycle pulse from the shift logic.
`include "spisf_defs.svh"

module spisf_rx_holding_stage
  import spisf_pkg::*;
(
  input  wire logic     aclk,
  input  wire logic     aresetn,
  spisf_rx_if.buf_side  rx
);
  logic drain_now;

  assign drain_now = rx.drain && rx.port_full;
  assign rx.loaded = drain_now ? (rx.stage_full || rx.rx_done) : (rx.rx_done && !rx.port_full);
  assign rx.lost   = !drain_now && rx.rx_done && rx.port_full && rx.stage_full;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx.port_full  <= 1'b0;
      rx.stage_full <= 1'b0;
      rx.port_data  <= '0;
      rx.stage_data <= '0;
    end else if (drain_now) begin
      if (rx.stage_full) begin
        rx.port_data  <= rx.stage_data;
        rx.stage_full <= rx.rx_done;
        if (rx.rx_done) rx.stage_data <= rx.rx_word;
      end else begin
        rx.port_full <= rx.rx_done;
        if (rx.rx_done) rx.port_data <= rx.rx_word;
      end
    end else if (rx.rx_done) begin
      if (!rx.port_full) begin
        rx.port_data <= rx.rx_word;
        rx.port_full <= 1'b1;
      end else begin
        // Overrun lands in the stage, never the port
        rx.stage_data <= rx.rx_word;
        rx.stage_full <= 1'b1;
      end
    end
  end
endmodule // spisf_rx_holding_stage

// ===== spisf_top.sv
// SPI status-flag block: flag register, receive port, vector and interrupt.
// Assumes shift, receive and error detection logic on the same aclk.
`include "spisf_defs.svh"

// Function
// - Word into shifter sets transmit-empty flag
// - Transmit data write or disable clears it
// - Word into receive port sets receive-full
// - Port read clears; debug peek does not
// - Vector read reporting receive-full clears it
// - Write one, disable or reset clear receive-full
// - Write-one clear discards pending port word
// - Full holding stage refills emptied port
// - Lost word sets overrun flag
// - Write one or overrun vector read clear
// - Port read never clears overrun
// - Overrun overwrites holding stage, not port
// - Error bits 0, 1 or 4 with both buffers full flag overrun
// - Error flags write-one-clear, reset zero
// - Reserved bits fixed value, writes ignored
module spisf_top
  import spisf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  spisf_addr_t      s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  spisf_word_t      s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  spisf_addr_t      s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output spisf_word_t      s_rdata,
  output logic [1:0]       s_rresp,
  input  wire logic        shift_load,
  input  wire logic        rx_done,
  input  spisf_rxw_t       rx_word,
  input  spisf_err_t       err_set,
  output logic             tx_write,
  output spisf_rxw_t       tx_word,
  output logic             tx_word_sel,
  output logic             enable,
  output logic             irq
);
  spisf_reg_if rif ();
  spisf_rx_if  rx ();

  logic         tx_empty_flag;
  logic         rx_full_flag;
  logic         rx_lost_flag;
  spisf_err_t   err_flags;
  spisf_flags_t flag_word;
  spisf_flags_t irq_status;
  spisf_flags_t irq_mask;
  spisf_flags_t events;
  spisf_vec_t   vec_code;
  spisf_addr_t  wa;
  spisf_addr_t  ra;
  logic         wr_flag;
  logic         wr_txa;
  logic         wr_txb;
  logic         wr_gcr;
  logic         wr_imask;
  logic         rd_port;
  logic         rd_peek;
  logic         rd_vec;
  logic         rd_istat;
  logic         dis_wr;
  spisf_flags_t w1c;
  logic         lost_set;
  spisf_flags_t mask_wr;

  ////////////////////////////////////////////////////////////////////////////
  spisf_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .awaddr  (s_awaddr),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .bresp   (s_bresp),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .araddr  (s_araddr),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rif     (rif.bus)
  );

  spisf_rx_holding_stage u_rx_holding_stage (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx      (rx.buf_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign wa       = {rif.wr_addr[`SPISF_ADDR_W-1:2], 2'h0};
  assign ra       = {rif.rd_addr[`SPISF_ADDR_W-1:2], 2'h0};
  assign wr_flag  = rif.wr_req && (wa == `SPISF_OFF_FLAG);
  assign wr_txa   = rif.wr_req && (wa == `SPISF_OFF_TXA);
  assign wr_txb   = rif.wr_req && (wa == `SPISF_OFF_TXB);
  assign wr_gcr   = rif.wr_req && (wa == `SPISF_OFF_GCR1);
  assign wr_imask = rif.wr_req && (wa == `SPISF_OFF_IMASK);
  assign rd_port  = rif.rd_req && (ra == `SPISF_OFF_PORT);
  assign rd_peek  = rif.rd_req && (ra == `SPISF_OFF_PEEK);
  assign rd_vec   = rif.rd_req && (ra == `SPISF_OFF_VEC1);
  assign rd_istat = rif.rd_req && (ra == `SPISF_OFF_ISTAT);
  assign dis_wr   = wr_gcr && rif.wr_strb[0] && !rif.wr_data[`SPISF_GCR_EN];
  // Reserved flag bits never take a write-one clear
  assign w1c = {{2{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}}
               & rif.wr_data[`SPISF_FLAG_W-1:0] & `SPISF_FLAG_IMPL
               & {`SPISF_FLAG_W{wr_flag}};

  always_comb begin
    rif.wr_err = !(wr_flag || wr_txa || wr_txb || wr_gcr || wr_imask);
  end

  assign flag_word = {tx_empty_flag, rx_full_flag, 1'b0, rx_lost_flag, 1'b0, err_flags};

  ////////////////////////////////////////////////////////////////////////////
  // Vector: highest pending unmasked source
  always_comb begin
    if (|(err_flags & irq_mask[`SPISF_ERR_W-1:0]))
      vec_code = `SPISF_VEC_ERR;
    else if (rx_lost_flag && irq_mask[`SPISF_B_LOST])
      vec_code = `SPISF_VEC_LOST;
    else if (rx_full_flag && irq_mask[`SPISF_B_RXF])
      vec_code = `SPISF_VEC_RXF;
    else if (tx_empty_flag && irq_mask[`SPISF_B_TXE])
      vec_code = `SPISF_VEC_TXE;
    else
      vec_code = `SPISF_VEC_NONE;
  end

  // Read mux
  always_comb begin
    rif.rd_data = '0;
    rif.rd_err  = 1'b0;
    case (ra)
      `SPISF_OFF_FLAG:
        rif.rd_data = {`SPISF_RSVD_VAL, flag_word};
      `SPISF_OFF_PORT, `SPISF_OFF_PEEK: begin
        rif.rd_data[`SPISF_RXW_W-1:0] = rx.port_data;
        rif.rd_data[`SPISF_EMPTY_BIT] = !rx.port_full;
      end
      `SPISF_OFF_VEC1:
        rif.rd_data[4:0] = vec_code;
      `SPISF_OFF_GCR1:
        rif.rd_data[`SPISF_GCR_EN] = enable;
      `SPISF_OFF_ISTAT:
        rif.rd_data[`SPISF_FLAG_W-1:0] = irq_status;
      `SPISF_OFF_IMASK:
        rif.rd_data[`SPISF_FLAG_W-1:0] = irq_mask;
      `SPISF_OFF_TXA, `SPISF_OFF_TXB:
        rif.rd_data = '0;
      default:
        rif.rd_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path control
  assign rx.rx_done = rx_done;
  assign rx.rx_word = rx_word;
  // Port read, or write-one clear of receive-full, drops the port word; a full stage refills the port
  assign rx.drain = rd_port || w1c[`SPISF_B_RXF];

  // Lost word, or error bit 0, 1 or 4 while both buffers hold unread words
  assign lost_set = rx.lost ||
                    (|(err_set & `SPISF_ERR_OVWR) && rx.port_full && rx.stage_full);

  ////////////////////////////////////////////////////////////////////////////
  // Flags; each set term is tested first
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_empty_flag <= 1'b0;
    else if (shift_load)
      tx_empty_flag <= 1'b1;
    else if (wr_txa || wr_txb || dis_wr)
      tx_empty_flag <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_full_flag <= 1'b0;
    else if (rx.loaded)
      rx_full_flag <= 1'b1;
    else if (rd_port || w1c[`SPISF_B_RXF] || dis_wr ||
             (rd_vec && vec_code == `SPISF_VEC_RXF))
      rx_full_flag <= 1'b0;
  end

  // Port reads leave overrun alone
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_lost_flag <= 1'b0;
    else if (lost_set)
      rx_lost_flag <= 1'b1;
    else if (w1c[`SPISF_B_LOST] || (rd_vec && vec_code == `SPISF_VEC_LOST))
      rx_lost_flag <= 1'b0;
  end

  for (genvar i = 0; i < `SPISF_ERR_W; i++) begin : g_err
    always_ff @(posedge aclk) begin
      if (!aresetn)
        err_flags[i] <= 1'b0;
      else if (err_set[i])
        err_flags[i] <= 1'b1;
      else if (w1c[i] || dis_wr)
        err_flags[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, transmit hand-off, interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn)
      enable <= 1'b0;
    else if (wr_gcr && rif.wr_strb[0])
      enable <= rif.wr_data[`SPISF_GCR_EN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_write    <= 1'b0;
      tx_word     <= '0;
      tx_word_sel <= 1'b0;
    end else begin
      tx_write <= wr_txa || wr_txb;
      if (wr_txa || wr_txb) begin
        tx_word     <= rif.wr_data[`SPISF_RXW_W-1:0];
        tx_word_sel <= wr_txb;
      end
    end
  end

  assign events = {shift_load, rx.loaded, 1'b0, lost_set, 1'b0, err_set};

  // Mask keeps only implemented flag positions
  assign mask_wr = rif.wr_data[`SPISF_FLAG_W-1:0] & `SPISF_FLAG_IMPL;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_status <= '0;
    else if (rd_istat)
      irq_status <= events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_mask <= '0;
    else if (wr_imask) begin
      if (rif.wr_strb[0]) irq_mask[7:0] <= mask_wr[7:0];
      if (rif.wr_strb[1]) irq_mask[9:8] <= mask_wr[9:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tx_set_a: assert property (shift_load |=> tx_empty_flag)
    else $error("transmit-empty not set by shift load");
  tx_clear_a: assert property ((wr_txb && !shift_load) |=> !tx_empty_flag && tx_write && tx_word_sel)
    else $error("transmit-empty not cleared by data write");
  rx_set_a: assert property ((rx_done && !rx.port_full) |=> rx_full_flag && rx.port_full)
    else $error("receive-full not set on port load");
  peek_keep_a: assert property ((rd_peek && rx_full_flag && !rif.wr_req) |=> rx_full_flag)
    else $error("debug peek cleared receive-full");
  vec_rxf_a: assert property ((rd_vec && vec_code == `SPISF_VEC_RXF && !rx.loaded)
                              |=> !rx_full_flag)
    else $error("vector read did not clear receive-full");
  dis_rxf_a: assert property ((dis_wr && !rx.loaded && !shift_load)
                              |=> !rx_full_flag && !tx_empty_flag)
    else $error("disable write did not clear flags");
  discard_a: assert property ((w1c[`SPISF_B_RXF] && rx.port_full && !rx.stage_full && !rx_done)
                              |=> !rx.port_full && !rx_full_flag)
    else $error("write-one clear did not discard port word");
  refill_a: assert property ((rx.drain && rx.port_full && rx.stage_full)
                             |=> rx.port_full && rx.port_data == $past(rx.stage_data))
    else $error("holding stage did not refill port");
  lost_set_a: assert property (rx.lost |=> rx_lost_flag && rx.stage_full)
    else $error("overrun flag not set on lost word");
  lost_clear_a: assert property ((w1c[`SPISF_B_LOST] && !lost_set) |=> !rx_lost_flag)
    else $error("overrun flag not cleared by write one");
  lost_keep_a: assert property ((rd_port && rx_lost_flag && !w1c[`SPISF_B_LOST])
                                |=> rx_lost_flag)
    else $error("port read cleared overrun flag");
  port_hold_a: assert property (rx.lost |=> rx.port_data == $past(rx.port_data))
    else $error("overrun wrote the receive port");
  err_ovwr_a: assert property ((err_set[1] && rx.port_full && rx.stage_full)
                               |=> rx_lost_flag)
    else $error("error with full buffers did not flag overrun");
  err_clear_a: assert property ((w1c[4] && !err_set[4]) |=> !err_flags[4])
    else $error("error flag not cleared by write one");
  rsvd_read_a: assert property ((rif.rd_req && ra == `SPISF_OFF_FLAG)
                                |=> s_rvalid && s_rdata[31:`SPISF_RSVD_LO] == `SPISF_RSVD_VAL
                                && !s_rdata[`SPISF_B_RSV7] && !s_rdata[`SPISF_B_RSV5])
    else $error("reserved flag bits read wrong");
  set_wins_a: assert property ((err_set[0] && w1c[0]) |=> err_flags[0])
    else $error("clear beat a same-cycle set");
  // Register-side clears seen from the bus
  txa_clear_a: assert property ((wr_txa && !shift_load) |=> !tx_empty_flag && tx_write && !tx_word_sel)
    else $error("transmit-empty not cleared by first data write");
  vec_lost_a: assert property ((rd_vec && vec_code == `SPISF_VEC_LOST && !lost_set)
                               |=> !rx_lost_flag)
    else $error("vector read did not clear overrun flag");
  port_clear_a: assert property ((rd_port && !rx.loaded) |=> !rx_full_flag)
    else $error("port read did not clear receive-full");
  w1c_refill_a: assert property ((w1c[`SPISF_B_RXF] && rx.stage_full) |=> rx_full_flag && rx.port_full)
    else $error("write-one clear did not refill port from stage");

  overrun_c: cover property (rx.lost ##[1:20] rd_vec && vec_code == `SPISF_VEC_LOST);
  refill_c: cover property (rd_port && rx.stage_full);
  irq_c: cover property (!irq ##1 irq ##[1:20] rd_istat);
  // Set and clear meeting in one cycle, discard with a waiting stage
  set_wins_c: cover property (err_set[0] && w1c[0]);
  discard_c: cover property (w1c[`SPISF_B_RXF] && rx.stage_full);
endmodule // spisf_top

// ===== tb.sv
// Self-checking bench for the SPI status-flag block, driven over AXI4-Lite.
// Assumes spisf_pkg and spisf_defs.svh; the bench pulses the status inputs itself.
`include "spisf_defs.svh"

module tb
  import spisf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0;
  logic        aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        shift_load, rx_done, tx_write, tx_word_sel, enable, irq;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [3:0]  s_wstrb;
  spisf_addr_t s_awaddr, s_araddr;
  spisf_word_t s_wdata, s_rdata, d;
  spisf_rxw_t  rx_word, tx_word;
  spisf_err_t  err_set;
  spisf_err_t  ecode [3] = '{5'h10, 5'h02, 5'h01};
  int          n_errors = 0;
  int          total_checks = 0;
  localparam spisf_word_t BASE = {`SPISF_RSVD_VAL, 10'h000};
  localparam spisf_word_t RXF  = 32'h0000_0100;
  localparam spisf_word_t LOST = 32'h0000_0040;
  localparam spisf_word_t TXE  = 32'h0000_0200;

  always #2 aclk = ~aclk;

  spisf_top u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .shift_load(shift_load), .rx_done(rx_done), .rx_word(rx_word), .err_set(err_set),
    .tx_write(tx_write), .tx_word(tx_word), .tx_word_sel(tx_word_sel),
    .enable(enable), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input spisf_word_t got, input spisf_word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input spisf_addr_t a, input spisf_word_t v);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= v;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input spisf_addr_t a);
    @(posedge aclk);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic cf(input spisf_addr_t a, input spisf_word_t e);
    rd(a);
    chk(d, e);
  endtask

  // One-cycle pulses on the status inputs
  task automatic ev(input logic sl, input logic rv, input spisf_rxw_t w, input spisf_err_t e);
    @(posedge aclk);
    shift_load <= sl;
    rx_done <= rv;
    rx_word <= w;
    err_set <= e;
    @(posedge aclk);
    shift_load <= 1'b0;
    rx_done <= 1'b0;
    err_set <= '0;
  endtask

  task automatic rx(input spisf_rxw_t w);
    ev(1'b0, 1'b1, w, 5'h00);
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test();
  end

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {shift_load, rx_done, s_awaddr, s_araddr, s_wdata, rx_word, err_set} = '0;
    s_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cf(`SPISF_OFF_FLAG, BASE);
    wr(`SPISF_OFF_GCR1, 32'h1);
    ev(1'b1, 1'b0, 16'h0000, 5'h00);
    cf(`SPISF_OFF_FLAG, BASE | TXE);
    wr(`SPISF_OFF_TXA, 32'h0000_1234);
    cf(`SPISF_OFF_FLAG, BASE);
    chk({15'h0, tx_word_sel, tx_word}, 32'h0000_1234);
    ev(1'b1, 1'b0, 16'h0000, 5'h00);
    wr(`SPISF_OFF_TXB, 32'h0000_5678);
    cf(`SPISF_OFF_FLAG, BASE);
    chk({15'h0, tx_word_sel, tx_word}, 32'h0001_5678);
    rx(16'ha1a1);
    cf(`SPISF_OFF_PEEK, 32'h0000_a1a1);
    cf(`SPISF_OFF_FLAG, BASE | RXF);
    cf(`SPISF_OFF_PORT, 32'h0000_a1a1);
    cf(`SPISF_OFF_FLAG, BASE);
    // Third word lands while port and stage are both full
    rx(16'h0001);
    rx(16'h0002);
    rx(16'h0003);
    cf(`SPISF_OFF_FLAG, BASE | RXF | LOST);
    cf(`SPISF_OFF_PORT, 32'h0000_0001);
    cf(`SPISF_OFF_FLAG, BASE | RXF | LOST);
    cf(`SPISF_OFF_PORT, 32'h0000_0003);
    wr(`SPISF_OFF_FLAG, LOST);
    cf(`SPISF_OFF_FLAG, BASE);
    rx(16'h0011);
    rx(16'h0012);
    wr(`SPISF_OFF_FLAG, RXF);
    cf(`SPISF_OFF_FLAG, BASE | RXF);
    cf(`SPISF_OFF_PORT, 32'h0000_0012);
    rx(16'h0013);
    wr(`SPISF_OFF_FLAG, RXF);
    rd(`SPISF_OFF_PORT);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    cf(`SPISF_OFF_FLAG, BASE);
    foreach (ecode[i]) begin
      rx(16'h0021);
      rx(16'h0022);
      ev(1'b0, 1'b0, 16'h0000, ecode[i]);
      cf(`SPISF_OFF_FLAG, BASE | RXF | LOST | 32'(ecode[i]));
      wr(`SPISF_OFF_FLAG, 32'hffff_ffff);
      cf(`SPISF_OFF_FLAG, BASE | RXF);
      cf(`SPISF_OFF_PORT, 32'h0000_0022);
    end
    ev(1'b0, 1'b0, 16'h0000, 5'h1f);
    cf(`SPISF_OFF_FLAG, BASE | 32'h1f);
    wr(`SPISF_OFF_FLAG, 32'h0000_0015);
    cf(`SPISF_OFF_FLAG, BASE | 32'h0a);
    wr(`SPISF_OFF_FLAG, 32'h0000_000a);
    // Error held high across its own write-one clear
    err_set <= 5'h01;
    wr(`SPISF_OFF_FLAG, 32'h0000_0001);
    err_set <= 5'h00;
    cf(`SPISF_OFF_FLAG, BASE | 32'h01);
    wr(`SPISF_OFF_FLAG, 32'h0000_0001);
    cf(`SPISF_OFF_FLAG, BASE);
    // Interrupt: masked, unmasked, vector read, status read clear
    wr(`SPISF_OFF_IMASK, 32'h0);
    rd(`SPISF_OFF_ISTAT);
    rx(16'h0031);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(`SPISF_OFF_IMASK, RXF);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    cf(`SPISF_OFF_VEC1, 32'h0000_0012);
    cf(`SPISF_OFF_FLAG, BASE);
    cf(`SPISF_OFF_ISTAT, RXF);
    cf(`SPISF_OFF_ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(`SPISF_OFF_PORT);
    wr(`SPISF_OFF_IMASK, LOST);
    rx(16'h0001);
    rx(16'h0002);
    rx(16'h0003);
    cf(`SPISF_OFF_VEC1, 32'h0000_0013);
    cf(`SPISF_OFF_FLAG, BASE | RXF);
    rd(`SPISF_OFF_PORT);
    rd(`SPISF_OFF_PORT);
    ev(1'b1, 1'b1, 16'h0041, 5'h1f);
    cf(`SPISF_OFF_FLAG, BASE | TXE | RXF | 32'h1f);
    wr(`SPISF_OFF_GCR1, 32'h0);
    cf(`SPISF_OFF_FLAG, BASE);
    chk({31'h0, enable}, 32'h0);
    rd(8'h40);
    chk(d, 32'h0);
    chk({30'h0, resp}, 32'h2);
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, 32'h2);
    stop_test();
  end
endmodule // tb
